// ==== design/mvia_arbiter.sv ====
// Multilevel vectored interrupt arbiter: gathers source requests into
// vectors, ranks them by level and vector address, and tracks the levels
// in service. Assumes requests are held by the peripherals until cleared.
//
// Overview of operation
// R01 - Three levels: highest above high above low
// R02 - Refuse requests at or below serviced level
// R03 - Simultaneous requests: highest level wins
// R04 - Same level: lowest vector address wins
// R05 - Twenty-one sources folded onto ten vectors
// R06 - Pin d, base timer, clock share vector
// R07 - Serial a, uart receive share vector
// R08 - Serial b, uart transmit share vector
// R09 - Converter, timers six/seven, SPI share vector
// R10 - Port zero, timers four/five share vector
// R11 - Other vectors eight apart, pins a/b topmost
// R12 - Refused request waits until level drops
`timescale 1ns/1ps

module mvia_arbiter #(
  parameter int NUM_VEC = mvia_pkg::NUM_VECTORS
) (
  input  wire logic                          REF_CLK,
  input  wire logic                          RESET_N,
  input  wire mvia_pkg::mvia_src_type        SRC,
  input  wire logic [NUM_VEC-1:0]            VEC_LVL_SEL,
  input  wire logic                          CPU_ACK,
  input  wire logic                          CPU_RETI,
  output logic                               IRQ_REQ,
  output mvia_pkg::mvia_lvl_type             IRQ_LEVEL,
  output logic [mvia_pkg::ADDR_W-1:0]        IRQ_VECTOR,
  output mvia_pkg::mvia_lvl_type             SERVICE_LEVEL
);

  // Ten vectors fixed by the source wiring
  initial begin
    if (NUM_VEC != mvia_pkg::NUM_VECTORS) begin
      $error("mvia_arbiter: NUM_VEC must equal the vector count");
    end
  end

  // ========================================================================
  // Functions

  // Level of one vector from its select bit
  function automatic mvia_pkg::mvia_lvl_type vec_level(input int idx, input logic sel);
    if (!sel) begin
      return mvia_pkg::LVL_LOW;
    end else if (mvia_pkg::TOP_CAPABLE[idx]) begin
      return mvia_pkg::LVL_TOP;
    end else begin
      return mvia_pkg::LVL_HIGH;
    end
  endfunction

  // R01 three ranked levels
  // Highest level flagged in service
  function automatic mvia_pkg::mvia_lvl_type top_of(input logic [3:1] flags);
    if (flags[3]) begin
      return mvia_pkg::LVL_TOP;
    end else if (flags[2]) begin
      return mvia_pkg::LVL_HIGH;
    end else if (flags[1]) begin
      return mvia_pkg::LVL_LOW;
    end else begin
      return mvia_pkg::LVL_NONE;
    end
  endfunction

  // ========================================================================
  // Source to vector folding
  logic [NUM_VEC-1:0]           vec_req;     // Any source of a vector
  mvia_pkg::mvia_lvl_type       vec_lvl [NUM_VEC]; // Level per vector

  // R05 source folding
  always_comb begin
    vec_req[0] = SRC.ext_pin_irq_a;
    vec_req[1] = SRC.ext_pin_irq_b;
    vec_req[2] = SRC.ext_pin_irq_c | SRC.timer_zero_low_event;
    // R06 shared timebase vector
    vec_req[3] = SRC.ext_pin_irq_d | SRC.base_timer_event | SRC.rtc_event;
    vec_req[4] = SRC.timer_zero_high_event;
    vec_req[5] = SRC.timer_one_low_event | SRC.timer_one_high_event;
    // R07 serial receive vector
    vec_req[6] = SRC.sync_serial_a | SRC.secondary_uart_rx;
    // R08 serial transmit vector
    vec_req[7] = SRC.async_sync_serial_b | SRC.uart_tx_event;
    // R09 converter and timers vector
    vec_req[8] = SRC.adc_event | SRC.timer_six_event | SRC.timer_seven_event
               | SRC.spi_rx_event;
    // R10 port zero vector
    vec_req[9] = SRC.port_zero_event | SRC.timer_four_event | SRC.timer_five_event;
  end

  // ========================================================================
  // Per-level candidates
  logic [NUM_VEC-1:0]           lvl_mask [1:3]; // Requests by level
  logic                         lvl_found [1:3]; // Any at that level
  logic [mvia_pkg::VEC_IDX_W-1:0] lvl_idx [1:3]; // Lowest vector at level

  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_vec
      // R11 selectable vector level
      assign vec_lvl[gv] = vec_level(gv, VEC_LVL_SEL[gv]);
      assign lvl_mask[1][gv] = vec_req[gv] && (vec_lvl[gv] == mvia_pkg::LVL_LOW);
      assign lvl_mask[2][gv] = vec_req[gv] && (vec_lvl[gv] == mvia_pkg::LVL_HIGH);
      assign lvl_mask[3][gv] = vec_req[gv] && (vec_lvl[gv] == mvia_pkg::LVL_TOP);
    end
    for (gv = 1; gv <= 3; gv++) begin : g_lvl
      // R04 lowest address within level
      mvia_first_set #(
        .N     (NUM_VEC),
        .IDX_W (mvia_pkg::VEC_IDX_W)
      ) u_first (
        .req   (lvl_mask[gv]),
        .found (lvl_found[gv]),
        .idx   (lvl_idx[gv])
      );
    end
  endgenerate

  // ========================================================================
  // In-service tracking
  logic [3:1]                   in_service;      // One flag per level
  logic [3:1]                   next_in_service; // After this cycle's events

  // Return clears the top flag first, then an accept sets its level
  always_comb begin
    next_in_service = in_service;
    if (CPU_RETI) begin
      case (top_of(in_service))
        mvia_pkg::LVL_TOP:  next_in_service[3] = 1'b0;
        mvia_pkg::LVL_HIGH: next_in_service[2] = 1'b0;
        mvia_pkg::LVL_LOW:  next_in_service[1] = 1'b0;
        default:            next_in_service = in_service;
      endcase
    end
    // Accept only counts while a request is shown
    if (CPU_ACK && IRQ_REQ && IRQ_LEVEL != mvia_pkg::LVL_NONE) begin
      next_in_service[IRQ_LEVEL] = 1'b1;
    end
  end

  // In-service flags
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      in_service <= 3'h0;
    end else begin
      in_service <= next_in_service;
    end
  end

  // Service level kept as its own flop for a clean output
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      SERVICE_LEVEL <= mvia_pkg::LVL_NONE;
    end else begin
      SERVICE_LEVEL <= top_of(next_in_service);
    end
  end

  // ========================================================================
  // Winner selection
  mvia_pkg::mvia_lvl_type       next_svc;   // Level in service next cycle
  mvia_pkg::mvia_grant_type     next_grant; // Request for next cycle
  logic [mvia_pkg::VEC_IDX_W-1:0] win_idx;  // Winning vector index

  // Judged against the next service level so an accepted request
  // drops in the very next cycle instead of lingering one extra.
  always_comb begin
    next_svc   = top_of(next_in_service);
    next_grant = '0;
    win_idx    = '0;
    // R03 higher level checked first
    if (lvl_found[3] && next_svc < mvia_pkg::LVL_TOP) begin
      next_grant.valid = 1'b1;
      next_grant.level = mvia_pkg::LVL_TOP;
      win_idx          = lvl_idx[3];
    // R02 at or below service refused
    end else if (lvl_found[2] && next_svc < mvia_pkg::LVL_HIGH) begin
      next_grant.valid = 1'b1;
      next_grant.level = mvia_pkg::LVL_HIGH;
      win_idx          = lvl_idx[2];
    end else if (lvl_found[1] && next_svc < mvia_pkg::LVL_LOW) begin
      next_grant.valid = 1'b1;
      next_grant.level = mvia_pkg::LVL_LOW;
      win_idx          = lvl_idx[1];
    end
    // R11 vectors spaced eight apart
    next_grant.addr = mvia_pkg::VEC_BASE + (16'(win_idx) << 3);
  end

  // R12 pending requests re-judged every cycle
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      IRQ_REQ    <= 1'b0;
      IRQ_LEVEL  <= mvia_pkg::LVL_NONE;
      IRQ_VECTOR <= '0;
    end else begin
      IRQ_REQ    <= next_grant.valid;
      IRQ_LEVEL  <= next_grant.level;
      IRQ_VECTOR <= next_grant.valid ? next_grant.addr : '0;
    end
  end

  // ========================================================================
  // Assertions

  // R02 no grant at or below service
  above_service_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R02
    IRQ_REQ |-> IRQ_LEVEL > SERVICE_LEVEL)
    else $error("Request shown at or below the service level");

  // R01 return removes top level first
  reti_order_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R01
    (CPU_RETI && !CPU_ACK && SERVICE_LEVEL == mvia_pkg::LVL_TOP && in_service[2])
    |=> SERVICE_LEVEL == mvia_pkg::LVL_HIGH)
    else $error("Return did not drop to the high level");

  // R03 highest level wins
  level_precedence_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R03
    (lvl_found[3] && lvl_found[1] && next_svc == mvia_pkg::LVL_NONE)
    |=> IRQ_LEVEL == mvia_pkg::LVL_TOP)
    else $error("Lower level beat a highest level request");

  // R04 lowest vector wins
  lowest_vector_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R04
    (vec_req[0] && vec_req[4] && VEC_LVL_SEL[0] == 1'b0 && VEC_LVL_SEL[4] == 1'b0
     && next_svc == mvia_pkg::LVL_NONE) |=> IRQ_VECTOR == 16'h0003)
    else $error("Lowest vector address did not win");

  // R05 every source reaches a vector
  source_fold_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R05
    (SRC != '0) |-> vec_req != '0)
    else $error("Active source reached no vector");

  // R06 clock source uses shared vector
  rtc_vector_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R06
    (SRC == mvia_pkg::mvia_src_type'(21'h004000) && next_svc == mvia_pkg::LVL_NONE)
    |=> IRQ_REQ && IRQ_VECTOR == 16'h001B)
    else $error("Clock source not on its shared vector");

  // R09 converter uses shared vector
  adc_vector_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R09
    (SRC == mvia_pkg::mvia_src_type'(21'h000040) && next_svc == mvia_pkg::LVL_NONE)
    |=> IRQ_REQ && IRQ_VECTOR == 16'h0043)
    else $error("Converter not on its shared vector");

  // R11 raised pin vector is topmost
  pin_top_level_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R11
    (IRQ_REQ && IRQ_VECTOR == 16'h0003) |-> IRQ_LEVEL != mvia_pkg::LVL_HIGH)
    else $error("Pin vector shown at the high level");

  // R12 refused request returns after drop
  pending_return_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N) // R12
    (CPU_RETI && !CPU_ACK && in_service == 3'h2 && lvl_found[2])
    |=> IRQ_REQ && IRQ_LEVEL >= mvia_pkg::LVL_HIGH)
    else $error("Waiting request not shown after service ended");

endmodule // mvia_arbiter

// ==== design/mvia_first_set.sv ====
// Lowest-index finder used once per priority level.
// Assumes a purely combinational use inside the arbiter.
`timescale 1ns/1ps

// ==========================================================================
// Lowest set bit
module mvia_first_set #(
  parameter int N     = 10,
  parameter int IDX_W = 4
) (
  input  wire logic [N-1:0]     req,
  output logic                  found,
  output logic [IDX_W-1:0]      idx
);

  // Index must be wide enough for every position
  initial begin
    if (N < 1 || (1 << IDX_W) < N) begin
      $error("mvia_first_set: IDX_W too small for N");
    end
  end

  // Scan downward so the lowest set bit is the last to write
  always_comb begin
    found = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx   = IDX_W'(i);
      end
    end
  end

endmodule // mvia_first_set

// ==== design/mvia_pkg.sv ====
// Shared constants and types for the multilevel vectored interrupt arbiter.
// Assumes one synchronous clock domain and a CPU core that answers with
// accept and return-from-interrupt pulses.
// ==========================================================================
// Package
package mvia_pkg;

  // Number of request sources and of vectors
  localparam int NUM_SOURCES = 21;
  localparam int NUM_VECTORS = 10;
  localparam int VEC_IDX_W   = 4;
  localparam int ADDR_W      = 16;

  // First vector address and the spacing between vectors
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;

  // Vectors whose raised level is highest rather than high
  localparam logic [9:0] TOP_CAPABLE = 10'h003;

  // Priority levels, numerically ordered so a larger code outranks a smaller
  typedef enum logic [1:0] {
    LVL_NONE = 2'h0,
    LVL_LOW  = 2'h1,
    LVL_HIGH = 2'h2,
    LVL_TOP  = 2'h3
  } mvia_lvl_type;

  // Request lines from the peripherals, one bit per source
  typedef struct packed {
    logic ext_pin_irq_a;          // Vector 0
    logic ext_pin_irq_b;          // Vector 1
    logic ext_pin_irq_c;          // Vector 2
    logic timer_zero_low_event;   // Vector 2
    logic ext_pin_irq_d;          // Vector 3
    logic base_timer_event;       // Vector 3
    logic rtc_event;              // Vector 3
    logic timer_zero_high_event;  // Vector 4
    logic timer_one_low_event;    // Vector 5
    logic timer_one_high_event;   // Vector 5
    logic sync_serial_a;          // Vector 6
    logic secondary_uart_rx;      // Vector 6
    logic async_sync_serial_b;    // Vector 7
    logic uart_tx_event;          // Vector 7
    logic adc_event;              // Vector 8
    logic timer_six_event;        // Vector 8
    logic timer_seven_event;      // Vector 8
    logic spi_rx_event;           // Vector 8
    logic port_zero_event;        // Vector 9
    logic timer_four_event;       // Vector 9
    logic timer_five_event;       // Vector 9
  } mvia_src_type;

  // Answer presented to the CPU core
  typedef struct packed {
    logic                 valid;  // Request to the core
    mvia_lvl_type         level;  // Level of the request
    logic [ADDR_W-1:0]    addr;   // Vector address
  } mvia_grant_type;

endpackage

// ==== dv/mvia_cpu_model.sv ====
// CPU core stand-in: accepts shown vectored requests, returns on command.
// Assumes registered arbiter outputs and one shared clock.
`timescale 1ns/1ps

// ==========================================================================
// Core model
module mvia_cpu_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        auto_ack,     // Accept shown requests
  input  wire logic [3:0]  ack_wait,     // Stall cycles before accepting
  input  wire logic        reti_go,      // Bench asks for a return
  output logic             cpu_ack,
  output logic             cpu_reti,
  output logic [15:0]      taken_vector  // Last accepted vector
);
  logic [3:0] wait_cnt;  // Cycles the request has stood

  // Accept after a stall; the ack edge itself is skipped so one request
  // is never taken twice while the arbiter drops it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_ack      <= 1'b0;
      wait_cnt     <= 4'h0;
      taken_vector <= 16'h0000;
    end else begin
      cpu_ack <= 1'b0;
      if (!irq_req || cpu_ack || !auto_ack) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == ack_wait) begin
        cpu_ack      <= 1'b1;
        taken_vector <= irq_vector;
        wait_cnt     <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end

  // One return pulse per bench request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_reti <= 1'b0;
    end else begin
      cpu_reti <= reti_go;
    end
  end
endmodule // mvia_cpu_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the vectored interrupt arbiter.
// Assumes the core model is compiled before this file.
`timescale 1ns/1ps

// ==========================================================================
// Bench top
module tb_top;
  logic                   ref_clk  = 1'b0;   // 40 MHz clock
  logic                   reset_n  = 1'b0;   // Synchronous, active low
  mvia_pkg::mvia_src_type src      = '0;     // Peripheral requests
  logic [9:0]             sel      = 10'h000; // Level select per vector
  logic                   auto_ack = 1'b0;   // Core accepts by itself
  logic [3:0]             ack_wait = 4'h2;   // Slow core: two stall cycles
  logic                   reti_go  = 1'b0;   // Return request
  logic                   cpu_ack;
  logic                   cpu_reti;
  logic                   irq_req;
  mvia_pkg::mvia_lvl_type irq_level;
  logic [15:0]            irq_vector;
  mvia_pkg::mvia_lvl_type service_level;
  logic [15:0]            taken_vector;
  int                     fail_count  = 0;
  int                     checks_done = 0;
  // Vector index of each source bit, bit 0 first
  int vmap [21] = '{9, 9, 9, 8, 8, 8, 8, 7, 7, 6, 6, 5, 5, 4, 3, 3, 3, 2, 2, 1, 0};

  // Free-running clock
  always #12.5 ref_clk = ~ref_clk;

  mvia_arbiter dut_u (.REF_CLK(ref_clk), .RESET_N(reset_n), .SRC(src), .VEC_LVL_SEL(sel),
    .CPU_ACK(cpu_ack), .CPU_RETI(cpu_reti), .IRQ_REQ(irq_req), .IRQ_LEVEL(irq_level),
    .IRQ_VECTOR(irq_vector), .SERVICE_LEVEL(service_level));
  mvia_cpu_model core_u (.clk(ref_clk), .rst_n(reset_n), .irq_req(irq_req),
    .irq_vector(irq_vector), .auto_ack(auto_ack), .ack_wait(ack_wait), .reti_go(reti_go),
    .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .taken_vector(taken_vector));

  // ========================================================================
  // Helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Let edges pass, then sample away from the edge
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic see(input logic req, input logic [1:0] lvl, input logic [15:0] vec);
    chk("irq_req", {15'h0, req}, {15'h0, irq_req});
    chk("irq_level", {14'h0, lvl}, {14'h0, irq_level});
    chk("irq_vector", vec, irq_vector);
  endtask

  task automatic svc(input logic [1:0] lvl);
    chk("service_level", {14'h0, lvl}, {14'h0, service_level});
  endtask

  // Sources held until changed; eight edges covers a slow accept
  task automatic drive(input logic [20:0] s, input logic [9:0] l);
    @(posedge ref_clk);
    src <= mvia_pkg::mvia_src_type'(s);
    sel <= l;
    settle(8);
  endtask

  task automatic reti();
    @(posedge ref_clk);
    reti_go <= 1'b1;
    @(posedge ref_clk);
    reti_go <= 1'b0;
    settle(6);
  endtask

  function automatic logic [15:0] vaddr(input int i);
    return 16'h0003 + 16'(i) * 16'h0008;
  endfunction

  // ========================================================================
  // Scenarios
  // every source alone, both level selections
  task automatic map_sources();
    for (int b = 0; b < 21; b++) begin
      drive(21'h000001 << b, 10'h000);
      see(1'b1, 2'h1, vaddr(vmap[b]));
      drive(21'h000001 << b, 10'h3FF);
      see(1'b1, (vmap[b] < 2) ? 2'h3 : 2'h2, vaddr(vmap[b]));
    end
    drive(21'h000000, 10'h000);
    see(1'b0, 2'h0, 16'h0000);
  endtask

  // level beats address, then address breaks ties
  task automatic precedence();
    drive(21'h020001, 10'h200);
    see(1'b1, 2'h2, 16'h004B);
    drive(21'h020001, 10'h000);
    see(1'b1, 2'h1, 16'h0013);
    drive(21'h102000, 10'h000);
    see(1'b1, 2'h1, 16'h0003);
    drive(21'h120000, 10'h001);
    see(1'b1, 2'h3, 16'h0003);
    drive(21'h120000, 10'h004);
    see(1'b1, 2'h2, 16'h0013);
    drive(21'h120000, 10'h005);
    see(1'b1, 2'h3, 16'h0003);
  endtask

  // nested service with a slow core
  task automatic nesting();
    @(posedge ref_clk);
    auto_ack <= 1'b1;
    drive(21'h002000, 10'h3FF);
    svc(2'h2);
    drive(21'h006000, 10'h3FF);
    see(1'b0, 2'h0, 16'h0000);
    drive(21'h106000, 10'h3FF);
    chk("taken", 16'h0003, taken_vector);
    svc(2'h3);
    drive(21'h004000, 10'h3FF);
    reti();
    svc(2'h2);
    see(1'b0, 2'h0, 16'h0000);
    reti();
    chk("taken", 16'h001B, taken_vector);
    svc(2'h2);
    drive(21'h000000, 10'h3FF);
    reti();
    svc(2'h0);
  endtask

  // Reset in mid-service drops the in-service level
  task automatic mid_reset();
    drive(21'h080000, 10'h002);
    svc(2'h3);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    settle(3);
    see(1'b0, 2'h0, 16'h0000);
    svc(2'h0);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    settle(8);
    chk("taken", 16'h000B, taken_vector);
    drive(21'h000000, 10'h000);
    reti();
    svc(2'h0);
  endtask

  // ========================================================================
  // Verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    map_sources();
    precedence();
    nesting();
    mid_reset();
    close_out();
  end

  // Watchdog, about five times the expected run
  initial begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
endmodule // tb_top
